// *** include/gated_timer_defines.vh ***
// Constants and register map of the sixteen-bit gated timer
`ifndef GATED_TIMER_DEFINES_VH
`define GATED_TIMER_DEFINES_VH

// Register byte offsets
`define ADDR_CONTROL      5'h00
`define ADDR_COUNT        5'h04
`define ADDR_PERIOD       5'h08
`define ADDR_STATUS       5'h0c
`define ADDR_MASK         5'h10

// Control field positions
`define BIT_RUN           15
`define BIT_IDLE_STOP     13
`define BIT_EXT_HI        9
`define BIT_EXT_LO        8
`define BIT_GATE          6
`define BIT_PS_HI         5
`define BIT_PS_LO         4
`define BIT_SYNC          2
`define BIT_CLK_SRC       1
`define CONTROL_WMASK     16'ha376

// Reset values
`define CONTROL_RESET     16'h0000
`define COUNT_RESET       16'h0000
`define PERIOD_RESET      16'hffff
`define STATUS_RESET      2'b00
`define MASK_RESET        2'b00

// Extended source codes
`define EXT_SECONDARY     2'b00
`define EXT_PIN           2'b01
`define EXT_LOW_POWER_RC_OSC          2'b10

// Status bits
`define ST_MATCH          0
`define ST_GATE_FALL      1

`endif

// *** hdl/edge_tick.v ***
// Rising-edge detector for one clock source, optional two-stage synchroniser
`timescale 1ns/1ps
module edge_tick
(
  input  wire clk_i,
  input  wire rst_i,
  input  wire src_i,
  input  wire sync_en_i,
  output wire tick_o
);
  reg s1_reg;
  reg s2_reg;
  reg last_reg;
  wire sample;

  // Synchronised path is two flops later; raw path samples directly
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s1_reg   <= 1'b0;
      s2_reg   <= 1'b0;
      last_reg <= 1'b0;
    end
    else
    begin
      s1_reg   <= src_i;
      s2_reg   <= s1_reg;
      last_reg <= sample;
    end
  end

  // Unsynchronised path still samples once; a true async domain is not modelled
  assign sample = sync_en_i ? s2_reg : src_i;
  assign tick_o = sample & ~last_reg;
endmodule // edge_tick

// *** hdl/gated_timer.v ***
// Sixteen-bit gated timer with Wishbone register access
`timescale 1ns/1ps
`include "gated_timer_defines.vh"
module gated_timer
(
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [4:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  output reg         err_o,
  input  wire        idle_i,
  input  wire        gate_i,
  input  wire        secondary_osc_i,
  input  wire        external_clock_pin_i,
  input  wire        low_power_rc_osc_i,
  output wire        irq_o
);
  reg  [15:0] control_reg;
  reg  [15:0] count_reg;
  reg  [15:0] period_reg;
  reg  [1:0]  status_reg;
  reg  [1:0]  mask_reg;
  reg  [7:0]  presc_reg;
  reg         gate_last_reg;
  reg  [15:0] wr_val;
  reg  [1:0]  status_next;
  reg  [31:0] rd_next;
  reg         ext_src;
  reg         presc_hit;
  reg         active;
  reg         in_tick;
  wire        ext_tick;
  wire        req;
  wire        wr;
  wire        rd;
  wire        hit_ctl;
  wire        hit_cnt;
  wire        hit_per;
  wire        hit_sts;
  wire        hit_msk;
  wire        mapped;
  wire        gate_mode;
  wire        gate_fall;
  wire        step;
  wire        match;

  // Lane merge for 16-bit registers in the low half of the word
  function [15:0] merge16;
    input [15:0] old_v;
    input [31:0] new_v;
    input [3:0]  sel;
    begin
      merge16[7:0]  = sel[0] ? new_v[7:0] : old_v[7:0];
      merge16[15:8] = sel[1] ? new_v[15:8] : old_v[15:8];
    end
  endfunction

  // Full five-bit compare, so no register aliases into a hole
  function addr_hit;
    input [4:0] adr;
    input [4:0] offset;
    begin
      addr_hit = (adr == offset);
    end
  endfunction

  // Upper lanes of a 16-bit register always read as zero
  function [31:0] widen16;
    input [15:0] v;
    begin
      widen16 = {16'h0000, v};
    end
  endfunction

  // Address decode
  assign req     = cyc_i & stb_i & ~ack_o & ~err_o;
  assign hit_ctl = addr_hit(adr_i, `ADDR_CONTROL);
  assign hit_cnt = addr_hit(adr_i, `ADDR_COUNT);
  assign hit_per = addr_hit(adr_i, `ADDR_PERIOD);
  assign hit_sts = addr_hit(adr_i, `ADDR_STATUS);
  assign hit_msk = addr_hit(adr_i, `ADDR_MASK);
  assign mapped  = hit_ctl | hit_cnt | hit_per | hit_sts | hit_msk;
  assign wr      = req & we_i & mapped;
  assign rd      = req & ~we_i & mapped;

  // Extended clock source mux; the reserved code counts nothing
  always @*
  begin
    case (control_reg[`BIT_EXT_HI:`BIT_EXT_LO])
      `EXT_SECONDARY: ext_src = secondary_osc_i;
      `EXT_PIN:       ext_src = external_clock_pin_i;
      `EXT_LOW_POWER_RC_OSC:      ext_src = low_power_rc_osc_i;
      default:        ext_src = 1'b0;
    endcase
  end

  edge_tick u_edge
  (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .src_i     (ext_src),
    .sync_en_i (control_reg[`BIT_SYNC]),
    .tick_o    (ext_tick)
  );

  // Gating only has meaning on the internal clock
  assign gate_mode = control_reg[`BIT_GATE] & ~control_reg[`BIT_CLK_SRC];
  assign gate_fall = gate_mode & control_reg[`BIT_RUN] & gate_last_reg & ~gate_i;

  // Input tick selection and run qualification
  always @*
  begin
    active = control_reg[`BIT_RUN] & ~(idle_i & control_reg[`BIT_IDLE_STOP]);
    if (control_reg[`BIT_CLK_SRC])
      in_tick = ext_tick;
    else
      in_tick = 1'b1;
    if (gate_mode & ~gate_i)
      in_tick = 1'b0;
    case (control_reg[`BIT_PS_HI:`BIT_PS_LO])
      2'b00:   presc_hit = 1'b1;
      2'b01:   presc_hit = (presc_reg[2:0] == 3'h7);
      2'b10:   presc_hit = (presc_reg[5:0] == 6'h3f);
      default: presc_hit = (presc_reg == 8'hff);
    endcase
  end

  assign step  = active & in_tick & presc_hit;
  assign match = (count_reg == period_reg);

  // Prescaler counts qualified input ticks
  always @(posedge clk_i)
  begin
    if (rst_i)
      presc_reg <= 8'h00;
    else if (wr & hit_ctl & control_reg[`BIT_RUN])
      presc_reg <= 8'h00;
    else if (active & in_tick)
      presc_reg <= presc_reg + 8'h01;
  end

  // Control, period, mask and counter
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      control_reg   <= `CONTROL_RESET;
      count_reg     <= `COUNT_RESET;
      period_reg    <= `PERIOD_RESET;
      mask_reg      <= `MASK_RESET;
      gate_last_reg <= 1'b0;
    end
    else
    begin
      gate_last_reg <= gate_i;
      if (wr & hit_ctl)
        control_reg <= merge16(control_reg, dat_i, sel_i) & `CONTROL_WMASK;
      if (wr & hit_per)
        period_reg <= merge16(period_reg, dat_i, sel_i);
      if (wr & hit_msk & sel_i[0])
        mask_reg <= dat_i[1:0];
      // Software write wins over a simultaneous tick
      if (wr & hit_cnt)
        count_reg <= merge16(count_reg, dat_i, sel_i);
      else if (step & match)
        count_reg <= 16'h0000;
      else if (step)
        count_reg <= count_reg + 16'h0001;
    end
  end

  // Sticky events: a new event beats the clear-on-read
  always @*
  begin
    status_next = status_reg;
    if (rd & hit_sts)
      status_next = 2'b00;
    if (step & match)
      status_next[`ST_MATCH] = 1'b1;
    if (gate_fall)
      status_next[`ST_GATE_FALL] = 1'b1;
  end

  always @(posedge clk_i)
  begin
    if (rst_i)
      status_reg <= `STATUS_RESET;
    else
      status_reg <= status_next;
  end

  assign irq_o = |(status_reg & mask_reg);

  // Read data mux
  always @*
  begin
    rd_next = 32'h0000_0000;
    if (hit_ctl)
      rd_next = widen16(control_reg);
    else if (hit_cnt)
      rd_next = widen16(count_reg);
    else if (hit_per)
      rd_next = widen16(period_reg);
    else if (hit_sts)
      rd_next = {30'h0, status_reg};
    else if (hit_msk)
      rd_next = {30'h0, mask_reg};
  end

  // One-cycle answer; unmapped addresses get err
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end
    else
    begin
      ack_o <= req & mapped;
      err_o <= req & ~mapped;
      if (rd)
        dat_o <= rd_next;
    end
  end
endmodule // gated_timer

// *** testbench/gated_timer_chk.sv ***
// Bus and register assertions for the gated timer
`timescale 1ns/1ps
module gated_timer_chk
(
  input wire        clk_i,
  input wire        rst_i,
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [4:0]  adr_i,
  input wire [31:0] dat_o,
  input wire        ack_o,
  input wire        err_o,
  input wire        irq_o
);
  // A request is taken only while no answer is standing
  wire req = cyc_i && stb_i && !ack_o && !err_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  answer_next_a:
    assert property (req |=> ack_o || err_o) else $error("no answer one cycle after request");
  ack_pulse_a:
    assert property (ack_o |=> !ack_o) else $error("ack stood longer than one cycle");
  one_answer_a:
    assert property (!(ack_o && err_o)) else $error("ack and err together");
  unmapped_err_a:
    assert property (req && adr_i[4] && adr_i[3:2] != 2'b00 |=> err_o && !ack_o) else $error("unmapped not refused");
  upper_zero_a:
    assert property (ack_o |-> dat_o[31:16] == 16'h0000) else $error("upper lanes not zero");
  ctrl_reserved_a:
    assert property (req && !we_i && adr_i == 5'h00 |=> (dat_o[15:0] & 16'h5c89) == 16'h0000)
      else $error("reserved control bits read nonzero");
  reset_quiet_a:
    assert property ($fell(rst_i) |-> !ack_o && !irq_o && dat_o == 32'h0) else $error("outputs not quiet after reset");
  ack_cause_a:
    assert property (ack_o |-> $past(req)) else $error("ack without request");
endmodule // gated_timer_chk

bind gated_timer gated_timer_chk u_chk
(
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .irq_o(irq_o)
);

// *** testbench/osc_model.sv ***
// Model of the three extended clock sources
`timescale 1ns/1ps
module osc_model
(
  input  wire  clk_i,
  input  wire  rst_i,
  input  wire  en_i,
  output logic secondary_osc_o,
  output logic external_clock_pin_o,
  output logic low_power_rc_osc_o
);
  logic [3:0] phase_reg;
  // Sources stand still while disabled, so no stray edges reach the timer
  always @(posedge clk_i)
    phase_reg <= (rst_i || !en_i) ? 4'h0 : phase_reg + 4'h1;
  // Distinct rates: a rising edge every 4, 8 and 16 clocks
  assign secondary_osc_o      = phase_reg[1];
  assign external_clock_pin_o = phase_reg[2];
  assign low_power_rc_osc_o   = phase_reg[3];
endmodule // osc_model

// *** testbench/gated_timer_bench.sv ***
// Register-level testbench for the gated timer
`timescale 1ns/1ps
module gated_timer_bench;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, idle_i, gate_i, osc_en, e;
  logic [4:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i;
  logic [15:0] q, ctl;
  wire  [31:0] dat_o;
  wire         ack_o, err_o, irq_o, sec_w, pin_w, low_power_rc_osc_w;
  int          fail_count, n_tests, dv[4];

  gated_timer u_dut
  (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .idle_i(idle_i), .gate_i(gate_i),
    .secondary_osc_i(sec_w), .external_clock_pin_i(pin_w), .low_power_rc_osc_i(low_power_rc_osc_w), .irq_o(irq_o)
  );
  osc_model u_osc
  (
    .clk_i(clk_i), .rst_i(rst_i), .en_i(osc_en),
    .secondary_osc_o(sec_w), .external_clock_pin_o(pin_w), .low_power_rc_osc_o(low_power_rc_osc_w)
  );

  task cmp(input string nm, input logic [15:0] exp, input logic [15:0] got, input int tol);
    n_tests++;
    if ((^got) === 1'bx || got > exp + tol || got + tol < exp)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One classic cycle; 16-bit value on lanes 1:0, held until the answer
  task wb(input logic w, input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {16'h0000, d};
    // Ack or err ends the wait; without either only the watchdog ends it
    do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
    q = dat_o[15:0];
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task rd(input string nm, input logic [4:0] a, input logic [15:0] exp, input int tol);
    wb(1'b0, a, 16'h0000);
    cmp(nm, exp, q, tol);
  endtask
  // Clear count, run for a span, then stop keeping the other fields
  task run(input logic [15:0] ctl, input int cyc);
    wb(1'b1, 5'h04, 16'h0000);
    wb(1'b1, 5'h00, ctl);
    repeat (cyc) @(posedge clk_i);
    wb(1'b1, 5'h00, ctl & 16'h7fff);
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Watchdog well beyond the roughly 6100 cycles the tests need
  initial
  begin
    repeat (60000) @(posedge clk_i);
    fail_count++;
    summarize;
  end
  initial
  begin
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, idle_i, gate_i, osc_en} = 6'h00;
    {adr_i, dat_i, sel_i} = {5'h00, 32'h0, 4'h3};
    dv = '{1, 8, 64, 256};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd("control rst", 5'h00, 16'h0000, 0);
    rd("count rst", 5'h04, 16'h0000, 0);
    rd("period rst", 5'h08, 16'hffff, 0);
    rd("status rst", 5'h0c, 16'h0000, 0);
    rd("mask rst", 5'h10, 16'h0000, 0);
    wb(1'b1, 5'h00, 16'hffff);
    rd("control bits", 5'h00, 16'ha376, 0);
    wb(1'b1, 5'h00, 16'h0000);
    wb(1'b0, 5'h14, 16'h0000);
    cmp("unmapped err", 16'h0001, {15'h0000, e}, 0);
    $display("test registers done");
    // Slack of three cycles covers the start and stop bus cycles
    for (int p = 0; p < 4; p++)
    begin
      run(16'h8000 | (p << 4), 16 * dv[p]);
      rd("prescaled count", 5'h04, (16 * dv[p] + 3) / dv[p], 2);
    end
    idle_i <= 1'b1;
    run(16'ha000, 32);
    rd("idle stopped", 5'h04, 16'h0000, 0);
    run(16'h8000, 16);
    rd("idle running", 5'h04, 16'h0013, 2);
    idle_i <= 1'b0;
    $display("test prescale and idle done");
    for (int c = 0; c < 4; c++)
    begin
      // Sources held low while the selector moves, so no false edge is counted
      ctl = 16'h8042 | (c << 8) | ((c & 1) << 2);
      osc_en <= 1'b0;
      wb(1'b1, 5'h04, 16'h0000);
      wb(1'b1, 5'h00, ctl);
      osc_en <= 1'b1;
      repeat (128) @(posedge clk_i);
      wb(1'b1, 5'h00, ctl & 16'h7fff);
      rd("ext count", 5'h04, (c == 3) ? 0 : 128 / (4 << c), (c == 3) ? 0 : 2);
    end
    osc_en <= 1'b0;
    $display("test sources done");
    wb(1'b1, 5'h04, 16'h0000);
    wb(1'b1, 5'h00, 16'h8040);
    repeat (32) @(posedge clk_i);
    gate_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    gate_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(1'b1, 5'h00, 16'h0040);
    rd("gated count", 5'h04, 16'h0010, 2);
    rd("gate fall flag", 5'h0c, 16'h0002, 0);
    $display("test gate done");
    wb(1'b1, 5'h08, 16'h0004);
    wb(1'b1, 5'h04, 16'h0000);
    wb(1'b1, 5'h00, 16'h8000);
    repeat (12) @(posedge clk_i);
    cmp("irq masked", 16'h0000, {15'h0000, irq_o}, 0);
    wb(1'b1, 5'h10, 16'h0001);
    cmp("irq unmasked", 16'h0001, {15'h0000, irq_o}, 0);
    wb(1'b1, 5'h00, 16'h0000);
    rd("wrapped count", 5'h04, 16'h0002, 2);
    rd("match flag", 5'h0c, 16'h0001, 0);
    rd("flag cleared", 5'h0c, 16'h0000, 0);
    cmp("irq cleared", 16'h0000, {15'h0000, irq_o}, 0);
    $display("test period done");
    // Rewrites every third cycle keep the 1:8 prescaler from ever reaching a tick
    wb(1'b1, 5'h04, 16'h0000);
    wb(1'b1, 5'h00, 16'h8010);
    repeat (6) wb(1'b1, 5'h00, 16'h8010);
    wb(1'b1, 5'h00, 16'h0010);
    rd("prescale restart", 5'h04, 16'h0000, 0);
    $display("test prescale restart done");
    summarize;
  end
endmodule // gated_timer_bench
